// ===== rtl/spp_pin_select.v
// Purpose: pin function select for the eight-pin serial channel port
// Assumes: rst is power-on reset only; manual reset and standby never reach it
// Notes:   pads are registered, so a mode change shows one cycle later
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "spp_consts.vh"

module spp_pin_select (
	input  wire                   clk,          // 200 MHz clock
	input  wire                   rst,          // power-on reset, sync, high
	input  wire [`SPP_ADDR_W-1:0] reg_addr,     // register byte address
	input  wire [`SPP_DATA_W-1:0] reg_wdata,    // write data
	input  wire                   reg_wr,       // write strobe
	input  wire                   reg_rd,       // read strobe
	output reg  [`SPP_DATA_W-1:0] reg_rdata,    // read data, cycle after strobe
	input  wire [2:0]             tx_enable_flag, // per channel transmit enable
	input  wire [2:0]             rx_enable_flag, // per channel receive enable
	input  wire [2:0]             sci_txd,      // serial transmit data per channel
	output reg  [2:0]             sci_rxd,      // serial receive data per channel
	input  wire [2:0]             txd_pin_in,   // transmit pad input levels
	output reg  [2:0]             txd_pin_out,  // transmit pad output levels
	output reg  [2:0]             txd_pin_oe,   // transmit pad output enables
	input  wire [2:0]             rxd_pin_in,   // receive pad input levels
	output reg  [2:0]             rxd_pin_pu,   // receive pad pull-up enables
	input  wire [4:0]             alt_out,      // alt outputs, pins 1,3,5,6,7
	input  wire [4:0]             alt_oe,       // alt output enables, pins 1,3,5,6,7
	output reg  [4:0]             alt_in,       // pad levels to alt functions
	input  wire [4:0]             io_pin_in,    // pad input levels, pins 1,3,5,6,7
	output reg  [4:0]             io_pin_out,   // pad output levels
	output reg  [4:0]             io_pin_oe,    // pad output enables
	output reg  [4:0]             io_pin_pu     // pad pull-up enables
);

	// written copy and the copy that actually steers the pads
	reg  [`SPP_DATA_W-1:0]      func_q;
	reg  [`SPP_DATA_W-1:0]      func_eff_q;
	reg  [`SPP_PIN_COUNT-1:0]   gpio_q;
	reg  [`SPP_PIN_COUNT-1:0]   gpio_d;
	reg  [`SPP_DATA_W-1:0]      rdata_d;
	wire [`SPP_PIN_COUNT-1:0]   read_val;
	wire                        serial_idle;

	// ordinary pin cell results, index 0..4 = pins 1,3,5,6,7
	wire [4:0]                  cell_out;
	wire [4:0]                  cell_oe;
	wire [4:0]                  cell_pu;
	wire [4:0]                  cell_rd;

	// shared pair results, index 0..2 = pins 0,2,4
	reg  [2:0]                  tx_out_d;
	reg  [2:0]                  tx_oe_d;
	reg  [2:0]                  rx_pu_d;
	reg  [2:0]                  pair_rd;

	// mode field of pin n
	function [1:0] field;
		input [`SPP_DATA_W-1:0] r;
		input integer           n;
		begin
			field = r[2*n +: `SPP_FIELD_W];
		end
	endfunction

	// register writes
	always @(posedge clk)
	begin
		if (rst)
		begin
			func_q <= `SPP_FUNC_RESET;
			gpio_q <= `SPP_DATA_RESET;
		end
		else
		begin
			if (reg_wr && reg_addr == `SPP_OFS_FUNC)
			begin
				func_q <= reg_wdata;
			end
			gpio_q <= gpio_d;
		end
	end

	always @*
	begin
		gpio_d = gpio_q;
		if (reg_wr && reg_addr == `SPP_OFS_DATA)
		begin
			gpio_d = reg_wdata[`SPP_PIN_COUNT-1:0];
		end
	end

	assign serial_idle = ~(|tx_enable_flag) & ~(|rx_enable_flag);

	// holding the old copy while a channel runs keeps a live link glitch free
	always @(posedge clk)
	begin
		if (rst)
		begin
			func_eff_q <= `SPP_FUNC_RESET;
		end
		else if (serial_idle)
		begin
			func_eff_q <= func_q;
		end
	end

	spp_pin_cell #(.RESERVED_OUT(1)) u_pin7 (
		.mode     (field(func_eff_q, 7)),
		.gpio_bit (gpio_q[7]),
		.alt_out  (alt_out[4]),
		.alt_oe   (alt_oe[4]),
		.pin_in   (io_pin_in[4]),
		.pad_out  (cell_out[4]),
		.pad_oe   (cell_oe[4]),
		.pull_up  (cell_pu[4]),
		.read_val (cell_rd[4])
	);

	spp_pin_cell #(.RESERVED_OUT(0)) u_pin6 (
		.mode     (field(func_eff_q, 6)),
		.gpio_bit (gpio_q[6]),
		.alt_out  (alt_out[3]),
		.alt_oe   (alt_oe[3]),
		.pin_in   (io_pin_in[3]),
		.pad_out  (cell_out[3]),
		.pad_oe   (cell_oe[3]),
		.pull_up  (cell_pu[3]),
		.read_val (cell_rd[3])
	);

	spp_pin_cell #(.RESERVED_OUT(0)) u_pin5 (
		.mode     (field(func_eff_q, 5)),
		.gpio_bit (gpio_q[5]),
		.alt_out  (alt_out[2]),
		.alt_oe   (alt_oe[2]),
		.pin_in   (io_pin_in[2]),
		.pad_out  (cell_out[2]),
		.pad_oe   (cell_oe[2]),
		.pull_up  (cell_pu[2]),
		.read_val (cell_rd[2])
	);

	spp_pin_cell #(.RESERVED_OUT(0)) u_pin3 (
		.mode     (field(func_eff_q, 3)),
		.gpio_bit (gpio_q[3]),
		.alt_out  (alt_out[1]),
		.alt_oe   (alt_oe[1]),
		.pin_in   (io_pin_in[1]),
		.pad_out  (cell_out[1]),
		.pad_oe   (cell_oe[1]),
		.pull_up  (cell_pu[1]),
		.read_val (cell_rd[1])
	);

	spp_pin_cell #(.RESERVED_OUT(0)) u_pin1 (
		.mode     (field(func_eff_q, 1)),
		.gpio_bit (gpio_q[1]),
		.alt_out  (alt_out[0]),
		.alt_oe   (alt_oe[0]),
		.pin_in   (io_pin_in[0]),
		.pad_out  (cell_out[0]),
		.pad_oe   (cell_oe[0]),
		.pull_up  (cell_pu[0]),
		.read_val (cell_rd[0])
	);

	// shared pairs: pair c uses field of pin 2c
	// channel 0, 1 and 2 pairs, one loop pass each
	always @*
	begin : pair_decode
		integer c;
		reg [1:0] m;
		c = 0;
		m = 2'b00;
		tx_out_d = 3'h0;
		tx_oe_d  = 3'h0;
		rx_pu_d  = 3'h0;
		pair_rd  = 3'h0;
		for (c = 0; c < 3; c = c + 1)
		begin
			m = field(func_eff_q, 2*c);
			pair_rd[c] = gpio_q[2*c];
			case (m)
			`SPP_SH_SERIAL:
			begin
				tx_out_d[c] = sci_txd[c];
				tx_oe_d[c]  = 1'b1;
			end
			`SPP_SH_GPO:
			begin
				tx_out_d[c] = gpio_q[2*c];
				tx_oe_d[c]  = 1'b1;
			end
			`SPP_SH_GPI_PU:
			begin
				tx_out_d[c] = sci_txd[c];
				tx_oe_d[c]  = tx_enable_flag[c];
				rx_pu_d[c]  = 1'b1;
				pair_rd[c]  = rxd_pin_in[c];
			end
			default:
			begin
				tx_out_d[c] = sci_txd[c];
				tx_oe_d[c]  = tx_enable_flag[c];
				pair_rd[c]  = rxd_pin_in[c];
			end
			endcase
			if (tx_enable_flag[c])
			begin
				tx_out_d[c] = sci_txd[c];
				tx_oe_d[c]  = 1'b1;
			end
		end
	end

	// data register view: pin level for inputs, stored bit otherwise
	assign read_val = {cell_rd[4], cell_rd[3], cell_rd[2], pair_rd[2],
		cell_rd[1], pair_rd[1], cell_rd[0], pair_rd[0]};

	always @*
	begin
		rdata_d = {`SPP_DATA_W{1'b0}};
		if (reg_rd && reg_addr == `SPP_OFS_FUNC)
		begin
			rdata_d = func_q;
		end
		else if (reg_rd && reg_addr == `SPP_OFS_DATA)
		begin
			rdata_d = {8'h00, read_val};
		end
	end

	// pads and read data come straight from flops
	always @(posedge clk)
	begin
		if (rst)
		begin
			reg_rdata   <= {`SPP_DATA_W{1'b0}};
			txd_pin_out <= 3'h0;
			txd_pin_oe  <= 3'h0;
			rxd_pin_pu  <= 3'h0;
			sci_rxd     <= 3'h7;
			io_pin_out  <= 5'h00;
			io_pin_oe   <= 5'h00;
			io_pin_pu   <= 5'h00;
			alt_in      <= 5'h00;
		end
		else
		begin
			reg_rdata   <= rdata_d;
			txd_pin_out <= tx_out_d;
			txd_pin_oe  <= tx_oe_d;
			rxd_pin_pu  <= rx_pu_d;
			sci_rxd     <= rxd_pin_in;
			io_pin_out  <= cell_out;
			io_pin_oe   <= cell_oe;
			io_pin_pu   <= cell_pu;
			alt_in      <= io_pin_in;
		end
	end

endmodule // spp_pin_select

// ===== rtl/spp_consts.vh
// Purpose: constants for the serial port pin function select block
// Assumes: byte addressed register port, 16-bit data lanes
// Notes:   included by every design file of the block
`ifndef SPP_CONSTS_VH
`define SPP_CONSTS_VH

// register port
`define SPP_ADDR_W      4
`define SPP_DATA_W      16
`define SPP_OFS_FUNC    4'h0
`define SPP_OFS_DATA    4'h4

// reset values
`define SPP_FUNC_RESET  16'ha888
`define SPP_DATA_RESET  8'h00

// mode field layout: pin n occupies bits 2n+1:2n
`define SPP_FIELD_W     2
`define SPP_PIN_COUNT   8
`define SPP_PIN7_LSB    14
`define SPP_PIN6_LSB    12
`define SPP_PIN5_LSB    10
`define SPP_PIN4_LSB    8
`define SPP_PIN3_LSB    6
`define SPP_PIN2_LSB    4
`define SPP_PIN1_LSB    2
`define SPP_PIN0_LSB    0

// ordinary pin codes
`define SPP_MD_ALT      2'b00
`define SPP_MD_OUT      2'b01
`define SPP_MD_IN_PU    2'b10
`define SPP_MD_IN_NOPU  2'b11

// shared pair codes
`define SPP_SH_SERIAL   2'b00
`define SPP_SH_GPO      2'b01
`define SPP_SH_GPI_PU   2'b10
`define SPP_SH_GPI_NOPU 2'b11

`endif

// ===== rtl/spp_pin_cell.v
// Purpose: mode decode for one ordinary (unshared) pin of the serial port
// Assumes: mode, data and alternate signals are stable registered values
// Notes:   purely combinational; the parent registers every pad output
`timescale 1ns/10ps
`include "spp_consts.vh"

module spp_pin_cell #(
	parameter RESERVED_OUT = 0                  // 1: code 01 is reserved for this pin
) (
	input  wire [1:0] mode,                     // effective mode field
	input  wire       gpio_bit,                 // general output data bit
	input  wire       alt_out,                  // alternate function output level
	input  wire       alt_oe,                   // alternate function output enable
	input  wire       pin_in,                   // pad input level
	output reg        pad_out,                  // pad output level
	output reg        pad_oe,                   // pad output enable
	output reg        pull_up,                  // pad pull-up enable
	output reg        read_val                  // value seen by a data register read
);

	always @*
	begin
		pad_out  = 1'b0;
		pad_oe   = 1'b0;
		pull_up  = 1'b0;
		read_val = gpio_bit;
		case (mode)
		`SPP_MD_ALT:
		begin
			pad_out = alt_out;
			pad_oe  = alt_oe;
		end
		`SPP_MD_OUT:
		begin
			if (RESERVED_OUT != 0)
			begin
				read_val = pin_in;
			end
			else
			begin
				pad_out = gpio_bit;
				pad_oe  = 1'b1;
			end
		end
		`SPP_MD_IN_PU:
		begin
			pull_up  = 1'b1;
			read_val = pin_in;
		end
		default:
		begin
			read_val = pin_in;
		end
		endcase
	end

endmodule // spp_pin_cell

// ===== testbench/spp_pin_select_asserts.sv
// Purpose: port-level checks for the serial port pin function select
// Assumes: pads follow the effective mode copy by one cycle
// Notes:   bound to every spp_pin_select instance
`timescale 1ns/10ps
`include "spp_consts.vh"

module spp_pin_select_asserts (
	input logic                   clk,            // clock
	input logic                   rst,            // reset
	input logic [`SPP_ADDR_W-1:0] reg_addr,       // address
	input logic [`SPP_DATA_W-1:0] reg_wdata,      // write data
	input logic                   reg_wr,         // write strobe
	input logic                   reg_rd,         // read strobe
	input logic [`SPP_DATA_W-1:0] reg_rdata,      // read data
	input logic [2:0]             tx_enable_flag, // tx enables
	input logic [2:0]             rx_enable_flag, // rx enables
	input logic [2:0]             sci_txd,        // serial tx
	input logic [2:0]             sci_rxd,        // serial rx
	input logic [2:0]             rxd_pin_in,     // rx pads
	input logic [2:0]             txd_pin_out,    // tx pad level
	input logic [2:0]             txd_pin_oe,     // tx pad enable
	input logic [2:0]             rxd_pin_pu,     // rx pull-ups
	input logic [4:0]             io_pin_oe,      // io enables
	input logic [4:0]             io_pin_pu       // io pull-ups
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire idle = ~|{tx_enable_flag, rx_enable_flag};

	function automatic logic [4:0] pu_of(input logic [15:0] r);
		pu_of = {r[15:14] == 2'b10, r[13:12] == 2'b10, r[11:10] == 2'b10, r[7:6] == 2'b10,
			r[3:2] == 2'b10};
	endfunction

	chk_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside its cycle");
	// waits for all three stages: written copy, effective copy, then pads; a newer write only reaches the pads two cycles after the check
	chk_write_reach: assert property (reg_wr && reg_addr == `SPP_OFS_FUNC && idle ##1 idle && !reg_wr ##1 idle |=> io_pin_pu == pu_of($past(reg_wdata, 3)))
		else $error("mode write not applied");
	chk_frozen_mode: assert property (!idle |-> ##2 $stable({io_pin_pu, rxd_pin_pu}))
		else $error("mode changed while serial active");
	chk_tx_drive: assert property ((txd_pin_oe & $past(tx_enable_flag)) == $past(tx_enable_flag))
		else $error("tx pin not driven");
	chk_tx_data: assert property (((txd_pin_out ^ $past(sci_txd)) & $past(tx_enable_flag)) == 3'b000)
		else $error("tx pin level wrong");
	chk_rx_follow: assert property (((sci_rxd ^ $past(rxd_pin_in)) & $past(rx_enable_flag)) == 3'b000)
		else $error("rx level not passed");
	chk_gpi_float: assert property ((rxd_pin_pu & txd_pin_oe & ~$past(tx_enable_flag)) == 3'b000)
		else $error("tx pin driven in input mode");
	chk_pull_input: assert property ((io_pin_pu & io_pin_oe) == 5'h00)
		else $error("pulled pin driven");
	cover property (reg_wr && !idle);
	cover property (|tx_enable_flag ##1 |txd_pin_oe);
	cover property (|rxd_pin_pu);
endmodule // spp_pin_select_asserts

bind spp_pin_select spp_pin_select_asserts i_chk (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .tx_enable_flag, .rx_enable_flag, .sci_txd, .sci_rxd, .rxd_pin_in,
	.txd_pin_out, .txd_pin_oe, .rxd_pin_pu, .io_pin_oe, .io_pin_pu);

// ===== testbench/spp_pad_model.sv
// Purpose: package pads and far-end line drivers
// Assumes: far transmitters drive the receive lines only when enabled
// Notes:   a floating pad toggles every cycle so it is never trusted
`timescale 1ns/10ps

module spp_pad_model (
	input  wire       clk,         // clock
	input  wire       ext_en,      // far end drives rx lines
	input  wire [2:0] ext_rx,      // far rx levels
	input  wire [2:0] txd_pin_out, // tx level
	input  wire [2:0] txd_pin_oe,  // tx enable
	input  wire [2:0] rxd_pin_pu,  // rx pull-up
	input  wire [4:0] io_pin_out,  // io level
	input  wire [4:0] io_pin_oe,   // io enable
	input  wire [4:0] io_pin_pu,   // io pull-up
	input  wire [4:0] ext_io_en,   // far end drives these io pads
	input  wire [4:0] ext_io,      // far io levels
	output wire [2:0] txd_pin_in,  // tx pad
	output wire [2:0] rxd_pin_in,  // rx pad
	output wire [4:0] io_pin_in    // io pad
);
	reg float_q = 1'b0;

	always @(posedge clk)
		float_q <= ~float_q;
	assign txd_pin_in = (txd_pin_oe & txd_pin_out) | (~txd_pin_oe & {3{float_q}});
	assign rxd_pin_in = ext_en ? ext_rx : (rxd_pin_pu | {3{float_q}});
	// a far driver only counts while the device itself leaves the pad alone
	assign io_pin_in  = (io_pin_oe & io_pin_out) | (~io_pin_oe & ext_io_en & ext_io)
		| (~io_pin_oe & ~ext_io_en & (io_pin_pu | {5{float_q}}));
endmodule // spp_pad_model

// ===== testbench/spp_pin_select_tb.sv
// Purpose: self-checking bench for spp_pin_select
// Assumes: pads settle within three edges of a mode write
// Notes:   second power-on reset checks the register restore
`timescale 1ns/10ps
`include "spp_consts.vh"

module spp_pin_select_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [2:0]  tx_enable_flag = 3'h0;
	logic [2:0]  rx_enable_flag = 3'h0;
	logic [2:0]  sci_txd = 3'h2;
	logic [2:0]  ext_rx = 3'h0;
	logic        ext_en = 1'b0;
	logic [4:0]  ext_io_en = 5'h00;
	logic [4:0]  ext_io = 5'h00;
	logic [4:0]  alt_out = 5'h1f;
	logic [4:0]  alt_oe = 5'h15;
	wire  [15:0] reg_rdata;
	wire  [2:0]  sci_rxd, txd_pin_in, txd_pin_out, txd_pin_oe, rxd_pin_in, rxd_pin_pu;
	wire  [4:0]  alt_in, io_pin_in, io_pin_out, io_pin_oe, io_pin_pu;
	int          err_total = 0;
	int          n_compared = 0;

	always #2.5 clk = ~clk;

	spp_pin_select i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.tx_enable_flag, .rx_enable_flag, .sci_txd, .sci_rxd, .txd_pin_in, .txd_pin_out,
		.txd_pin_oe, .rxd_pin_in, .rxd_pin_pu, .alt_out, .alt_oe, .alt_in, .io_pin_in,
		.io_pin_out, .io_pin_oe, .io_pin_pu);
	spp_pad_model i_pads (.clk, .ext_en, .ext_rx, .txd_pin_out, .txd_pin_oe, .rxd_pin_pu,
		.io_pin_out, .io_pin_oe, .io_pin_pu, .ext_io_en, .ext_io, .txd_pin_in, .rxd_pin_in,
		.io_pin_in);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask

	task automatic t_power_on();
		@(posedge clk);
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		settle();
		rd(`SPP_OFS_FUNC, `SPP_FUNC_RESET);
		check(16'(io_pin_pu), 16'h001f);
		check(16'(txd_pin_oe), 16'h0007);
		check(16'(txd_pin_out), 16'(sci_txd));
		rd(4'h2, 16'h0000);
		rd(`SPP_OFS_DATA, 16'h00ea);
	endtask

	task automatic t_modes();
		// far end holds pins 3 and 6 low and pin 7 high so pad reads are known
		@(posedge clk);
		ext_io_en <= 5'h1a;
		ext_io <= 5'h10;
		wr(`SPP_OFS_DATA, 16'h0013);
		for (int k = 0; k < 4; k++)
		begin
			wr(`SPP_OFS_FUNC, {8{k[1:0]}});
			settle();
			rd(`SPP_OFS_FUNC, {8{k[1:0]}});
			check(16'(io_pin_oe), k == 0 ? 16'h0015 : (k == 1 ? 16'h000f : 16'h0));
			check(16'(io_pin_out & io_pin_oe), k == 0 ? 16'h0015 : 16'(k == 1));
			check(16'(io_pin_pu), k == 2 ? 16'h001f : 16'h0000);
			check(16'(txd_pin_oe), k < 2 ? 16'h0007 : 16'h0000);
			check(16'(txd_pin_out & txd_pin_oe), k == 0 ? 16'h2 : (k == 1 ? 16'h5 : 16'h0));
			check(16'(rxd_pin_pu), k == 2 ? 16'h0007 : 16'h0000);
			if (k < 3)
			begin
				rd(`SPP_OFS_DATA, k == 2 ? 16'h00b7 : (k == 1 ? 16'h0093 : 16'h0013));
				check(16'(alt_in), k == 1 ? 16'h0011 : 16'h0015);
			end
		end
		@(posedge clk);
		ext_io_en <= 5'h00;
	endtask

	task automatic t_override();
		// general output on the pairs shows whether transmit enable really takes over
		wr(`SPP_OFS_FUNC, 16'h0111);
		settle();
		@(posedge clk);
		tx_enable_flag <= 3'h7;
		settle();
		check(16'(txd_pin_oe), 16'h0007);
		check(16'(txd_pin_out), 16'(sci_txd));
		@(posedge clk);
		tx_enable_flag <= 3'h0;
		wr(`SPP_OFS_FUNC, 16'hffff);
		settle();
		@(posedge clk);
		rx_enable_flag <= 3'h7;
		ext_en <= 1'b1;
		ext_rx <= 3'h6;
		wr(`SPP_OFS_FUNC, 16'ha888);
		settle();
		check(16'(txd_pin_oe), 16'h0000);
		check(16'(sci_rxd), 16'h0006);
		check(16'(io_pin_pu), 16'h0000);
		rd(`SPP_OFS_FUNC, 16'ha888);
		@(posedge clk);
		rx_enable_flag <= 3'h0;
		ext_en <= 1'b0;
		settle();
		check(16'(io_pin_pu), 16'h001f);
	endtask

	task automatic conclude();
		if (err_total == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		#50000;
		err_total++;
		conclude();
	end

	initial
	begin
		t_power_on();
		t_modes();
		t_override();
		wr(`SPP_OFS_FUNC, 16'h0000);
		t_power_on();
		conclude();
	end
endmodule // spp_pin_select_tb
